// ===== verilog/twse_pkg.sv
// constants, codes and carrier types of the two-wire slave engine
// assumes an 8-bit register port and a bus sampled by the system clock
package twse_pkg;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam int          ADDR_W         = 3;
  localparam logic [2:0]  OFS_OWN_ADDR   = 3'h0;
  localparam logic [2:0]  OFS_CONTROL    = 3'h1;
  localparam logic [2:0]  OFS_STATE_CODE = 3'h2;
  localparam logic [2:0]  OFS_BYTE_BUF   = 3'h3;
  localparam int          CTL_FLAG       = 7;
  localparam int          CTL_ACK        = 6;
  localparam int          CTL_STA        = 5;
  localparam int          CTL_STO        = 4;
  localparam int          CTL_WCOL       = 3;
  localparam int          CTL_ENA        = 2;
  localparam int          CTL_IE         = 0;
  localparam int          OAR_GCE        = 0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [6:0]  GC_ADDR        = 7'h00;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT    = 4'h7;

  // ---------------------------------------------------------------
  // status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] SC_OWN_W   = 8'h60;
  localparam logic [7:0] SC_ARB_W   = 8'h68;
  localparam logic [7:0] SC_GC_W    = 8'h70;
  localparam logic [7:0] SC_ARB_GC  = 8'h78;
  localparam logic [7:0] SC_RX_ACK  = 8'h80;
  localparam logic [7:0] SC_RX_NACK = 8'h88;
  localparam logic [7:0] SC_GC_ACK  = 8'h90;
  localparam logic [7:0] SC_GC_NACK = 8'h98;
  localparam logic [7:0] SC_STOP    = 8'hA0;
  localparam logic [7:0] SC_OWN_R   = 8'hA8;
  localparam logic [7:0] SC_ARB_R   = 8'hB0;
  localparam logic [7:0] SC_TX_ACK  = 8'hB8;
  localparam logic [7:0] SC_TX_NACK = 8'hC0;
  localparam logic [7:0] SC_TX_LAST = 8'hC8;
  localparam logic [7:0] SC_NONE    = 8'hF8;
  localparam logic [7:0] SC_MASK    = 8'hF8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK,
    ST_TX, ST_TX_ACK, ST_HOLD, ST_IGNORE
  } twse_state_type;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } twse_bus_type;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } twse_pins_type;

  typedef struct packed {
    twse_state_type st;
    logic [1:0]     scl_s;
    logic [1:0]     sda_s;
    logic           scl_q;
    logic           sda_q;
    logic [7:0]     oar;
    logic [7:0]     buf_b;
    logic [7:0]     shf;
    logic [7:0]     code;
    logic [7:0]     rdata;
    logic [3:0]     cnt;
    logic           flag;
    logic           ack_en;
    logic           sta;
    logic           sto;
    logic           wcol;
    logic           ena;
    logic           ie;
    logic           gc;
    logic           tx;
    logic           last;
    logic           mack;
    logic           nack;
    logic           busy;
    logic           pend;
    logic           go;
    logic           wake;
    twse_pins_type  pins;
  } twse_regs_type;

endpackage : twse_pkg

// ===== verilog/twse_engine.sv
// slave engine of the two-wire serial unit: address match, slave
// receive and transmit, status codes and clock stretching.
// assumes scl_in/sda_in are raw pin levels and the bus clock is far
// slower than ref_clk; the register port is on ref_clk.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module twse_engine
  import twse_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire twse_bus_type  bus,
  output var  logic [7:0]    rd_data,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output var  twse_pins_type pins,
  output var  logic          scl_out,
  output var  logic          sda_out,
  input  wire logic          deep_sleep,
  input  wire logic          arb_lost,
  output var  logic          wake_req,
  output var  logic          start_go
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // codes after which the engine leaves the bus once the flag clears
  function automatic logic is_term(input logic [7:0] c);
    return c == SC_RX_NACK || c == SC_GC_NACK || c == SC_STOP ||
           c == SC_TX_NACK || c == SC_TX_LAST;
  endfunction : is_term

  function automatic logic is_txc(input logic [7:0] c);
    return c == SC_OWN_R || c == SC_ARB_R || c == SC_TX_ACK;
  endfunction : is_txc

  twse_regs_type q_reg;
  twse_regs_type q_next;
  logic          rise;
  logic          fall;
  logic          start_c;
  logic          stop_c;
  logic          clr;
  logic          own_m;
  logic          gc_m;
  logic          addressed;
  logic [7:0]    ctl_v;

  // ---------------------------------------------------------------
  // bus events, seen only through the second synchroniser stage
  // ---------------------------------------------------------------
  always_comb begin
    rise    = q_reg.scl_s[1] & ~q_reg.scl_q;
    fall    = ~q_reg.scl_s[1] & q_reg.scl_q;
    start_c = q_reg.scl_s[1] & q_reg.scl_q & q_reg.sda_q & ~q_reg.sda_s[1];
    stop_c  = q_reg.scl_s[1] & q_reg.scl_q & ~q_reg.sda_q & q_reg.sda_s[1];
    clr     = bus.wr && bus.addr == OFS_CONTROL &&
              bus.wdata[CTL_FLAG] && q_reg.flag;
    own_m   = q_reg.shf[7:1] == q_reg.oar[7:1];
    gc_m    = q_reg.shf[7:1] == GC_ADDR && q_reg.oar[OAR_GCE] &&
              !q_reg.shf[0];
    addressed = q_reg.st == ST_RX || q_reg.st == ST_RX_ACK ||
                q_reg.st == ST_TX || q_reg.st == ST_TX_ACK;
    ctl_v   = {q_reg.flag, q_reg.ack_en, q_reg.sta, q_reg.sto,
               q_reg.wcol, q_reg.ena, 1'b0, q_reg.ie};
  end

  // ---------------------------------------------------------------
  // next state: registers, resume, bus machine
  // ---------------------------------------------------------------
  always_comb begin
    q_next       = q_reg;
    q_next.scl_s = {q_reg.scl_s[0], scl_in};
    q_next.sda_s = {q_reg.sda_s[0], sda_in};
    q_next.scl_q = q_reg.scl_s[1];
    q_next.sda_q = q_reg.sda_s[1];
    q_next.go    = 1'b0;
    q_next.rdata = RST_BYTE;
    // read port; prescaler bits always read zero
    if (bus.rd) begin
      if (bus.addr == OFS_OWN_ADDR) begin
        q_next.rdata = q_reg.oar;
      end else if (bus.addr == OFS_CONTROL) begin
        q_next.rdata = ctl_v;
      end else if (bus.addr == OFS_STATE_CODE) begin
        q_next.rdata = q_reg.flag ? (q_reg.code & SC_MASK) : SC_NONE;
      end else if (bus.addr == OFS_BYTE_BUF) begin
        q_next.rdata = q_reg.buf_b;
      end
    end
    // write port
    if (bus.wr) begin
      if (bus.addr == OFS_OWN_ADDR) begin
        q_next.oar = bus.wdata;
      end else if (bus.addr == OFS_CONTROL) begin
        q_next.ack_en = bus.wdata[CTL_ACK];   // takes effect at next address match or received data byte
        q_next.sta    = bus.wdata[CTL_STA];
        q_next.sto    = bus.wdata[CTL_STO];
        q_next.ena    = bus.wdata[CTL_ENA];
        q_next.ie     = bus.wdata[CTL_IE];
      end else if (bus.addr == OFS_BYTE_BUF) begin
        // loading while the engine owns the byte is a collision
        if (q_reg.flag) begin
          q_next.buf_b = bus.wdata;
          q_next.wcol  = 1'b0;
        end else begin
          q_next.wcol = 1'b1;
        end
      end
    end
    // resume once software writes one to the flag
    if (clr) begin
      q_next.flag        = 1'b0;
      q_next.pins.scl_oe = 1'b0;
      q_next.cnt         = 4'h0;
      if (bus.wdata[CTL_STO]) begin
        q_next.st  = ST_IDLE;
        q_next.sto = 1'b0;
      end else if (is_term(q_reg.code)) begin
        q_next.st   = ST_IDLE;
        q_next.pend = bus.wdata[CTL_STA];
      end else if (is_txc(q_reg.code)) begin
        q_next.st          = ST_TX;
        q_next.shf         = q_reg.buf_b;
        q_next.last        = !bus.wdata[CTL_ACK];
        q_next.pins.sda_oe = !q_reg.buf_b[7];
      end else begin
        q_next.st = ST_RX;
      end
    end
    // start request waits for a free bus
    if (q_reg.pend && !q_reg.busy && !start_c) begin
      q_next.go   = 1'b1;
      q_next.pend = 1'b0;
    end
    if (start_c) begin
      q_next.busy = 1'b1;
    end else if (stop_c) begin
      q_next.busy = 1'b0;
    end
    if (!deep_sleep) begin
      q_next.wake = 1'b0;
    end
    // bus machine; a set of the flag here wins over a clear above
    if (!q_reg.ena) begin
      q_next.st   = ST_IDLE;
      q_next.pins = '0;
    end else if ((start_c || stop_c) && q_reg.st != ST_HOLD) begin
      q_next.pins.sda_oe = 1'b0;
      q_next.cnt         = 4'h0;
      if (addressed) begin
        q_next.st   = ST_HOLD;
        q_next.flag = 1'b1;
        q_next.code = SC_STOP;
      end else begin
        q_next.st = start_c ? ST_ADDR : ST_IDLE;
      end
    end else begin
      case (q_reg.st)
        ST_ADDR: begin
          if (rise) begin
            q_next.shf = {q_reg.shf[6:0], q_reg.sda_s[1]};
            q_next.cnt = q_reg.cnt + 4'h1;
          end else if (fall && q_reg.cnt == BYTE_BITS) begin
            // no ack_enable, no answer; the bus is still watched
            if (q_reg.ack_en && (own_m || gc_m)) begin
              q_next.st          = ST_ADDR_ACK;
              q_next.pins.sda_oe = 1'b1;
              q_next.gc          = gc_m && !own_m;
              q_next.tx          = q_reg.shf[0];
              q_next.wake        = deep_sleep;
            end else begin
              q_next.st = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall) begin
            q_next.pins.sda_oe = 1'b0;
            q_next.pins.scl_oe = 1'b1;
            q_next.flag        = 1'b1;
            q_next.st          = ST_HOLD;
            if (q_reg.tx) begin
              q_next.code = arb_lost ? SC_ARB_R : SC_OWN_R;
            end else if (q_reg.gc) begin
              q_next.code = arb_lost ? SC_ARB_GC : SC_GC_W;
            end else begin
              q_next.code = arb_lost ? SC_ARB_W : SC_OWN_W;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            q_next.shf = {q_reg.shf[6:0], q_reg.sda_s[1]};
            q_next.cnt = q_reg.cnt + 4'h1;
          end else if (fall && q_reg.cnt == BYTE_BITS) begin
            q_next.pins.sda_oe = q_reg.ack_en;
            q_next.nack        = !q_reg.ack_en;
            q_next.st          = ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (fall) begin
            // sleeping keeps the buffer untouched; its content is stale
            if (!deep_sleep) begin
              q_next.buf_b = q_reg.shf;
            end
            q_next.pins.sda_oe = 1'b0;
            q_next.pins.scl_oe = 1'b1;
            q_next.flag        = 1'b1;
            q_next.st          = ST_HOLD;
            if (q_reg.gc) begin
              q_next.code = q_reg.nack ? SC_GC_NACK : SC_GC_ACK;
            end else begin
              q_next.code = q_reg.nack ? SC_RX_NACK : SC_RX_ACK;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            q_next.cnt = q_reg.cnt + 4'h1;
            if (q_reg.cnt == TX_LAST_BIT) begin
              q_next.pins.sda_oe = 1'b0;
              q_next.st          = ST_TX_ACK;
            end else begin
              q_next.shf         = {q_reg.shf[6:0], 1'b0};
              q_next.pins.sda_oe = !q_reg.shf[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            q_next.mack = !q_reg.sda_s[1];
          end else if (fall) begin
            q_next.pins.scl_oe = 1'b1;
            q_next.flag        = 1'b1;
            q_next.st          = ST_HOLD;
            if (!q_reg.mack) begin
              q_next.code = SC_TX_NACK;
            end else begin
              q_next.code = q_reg.last ? SC_TX_LAST : SC_TX_ACK;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // a stop leaves the bus free, so nothing is stretched for it
    if (q_next.code == SC_STOP) begin
      q_next.pins.scl_oe = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register, synchronous reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q_reg       <= '0;
      q_reg.st    <= ST_IDLE;
      q_reg.scl_s <= 2'b11;
      q_reg.sda_s <= 2'b11;
      q_reg.scl_q <= 1'b1;
      q_reg.sda_q <= 1'b1;
      q_reg.code  <= SC_NONE;
    end else begin
      q_reg <= q_next;
    end
  end

  // outputs straight from flops; open-drain lines only pull low
  always_comb begin
    rd_data  = q_reg.rdata;
    pins     = q_reg.pins;
    scl_out  = 1'b0;
    sda_out  = 1'b0;
    wake_req = q_reg.wake;
    start_go = q_reg.go;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  AST_OWN_MATCH: assert property (
    q_reg.ena && !start_c && !stop_c && q_reg.st == ST_ADDR && fall &&
    q_reg.cnt == BYTE_BITS && q_reg.ack_en && own_m
    |=> q_reg.st == ST_ADDR_ACK && pins.sda_oe)
    else $error("own address not acknowledged");
  AST_GC_GATE: assert property (
    q_reg.st == ST_ADDR && fall && q_reg.cnt == BYTE_BITS &&
    q_reg.shf == RST_BYTE && !q_reg.oar[OAR_GCE] && !own_m
    |=> q_reg.st != ST_ADDR_ACK)
    else $error("general call answered while disabled");
  AST_NO_ACK_OFF: assert property (
    q_reg.ena && !start_c && !stop_c && q_reg.st == ST_ADDR && fall &&
    q_reg.cnt == BYTE_BITS && !q_reg.ack_en
    |=> q_reg.st == ST_IGNORE ##1 !pins.sda_oe)
    else $error("address answered with ack_enable low");
  AST_ADDR_FLAG: assert property (
    q_reg.ena && !start_c && !stop_c && q_reg.st == ST_ADDR_ACK && fall
    |=> q_reg.flag && pins.scl_oe && !pins.sda_oe)
    else $error("flag not set after address");
  AST_DIR_READ: assert property (
    q_reg.ena && !start_c && !stop_c && q_reg.st == ST_ADDR_ACK && fall &&
    q_reg.tx
    |=> q_reg.code == SC_OWN_R || q_reg.code == SC_ARB_R)
    else $error("read direction gave receive code");
  AST_TX_END: assert property (
    q_reg.ena && !start_c && !stop_c && q_reg.st == ST_TX_ACK && fall
    |=> q_reg.code == (!$past(q_reg.mack) ? SC_TX_NACK :
        $past(q_reg.last) ? SC_TX_LAST : SC_TX_ACK))
    else $error("wrong code after transmitted byte");
  AST_STOP_CODE: assert property (
    q_reg.ena && stop_c && addressed
    |=> q_reg.flag && q_reg.code == SC_STOP && !pins.scl_oe)
    else $error("stop while addressed not reported");
  AST_TERM_IDLE: assert property (
    clr && is_term(q_reg.code) && q_reg.ena && !start_c
    |=> q_reg.st == ST_IDLE ##1 !pins.sda_oe)
    else $error("terminal state did not release bus");
  AST_STRETCH: assert property (
    $rose(q_reg.flag) && q_reg.code != SC_STOP
    |-> pins.scl_oe until_with clr)
    else $error("clock released before flag cleared");
  AST_STRETCH_END: assert property (
    clr |=> !pins.scl_oe)
    else $error("clock still held after flag cleared");
  AST_GC_RX_ACK: assert property (
    q_reg.ena && !start_c && !stop_c && q_reg.st == ST_RX && fall &&
    q_reg.cnt == BYTE_BITS |=> pins.sda_oe == $past(q_reg.ack_en))
    else $error("data ack does not follow ack_enable");
  AST_STAT_MASK: assert property (
    bus.rd && bus.addr == OFS_STATE_CODE |=> rd_data[1:0] == 2'b00)
    else $error("prescaler bits not zero");
  AST_START_GO: assert property (
    start_go |-> $past(q_reg.pend) && !$past(q_reg.busy))
    else $error("start issued on busy bus");

  COV_OWN_READ: cover property (q_reg.code == SC_OWN_R && q_reg.flag);
  COV_GC_DATA: cover property (q_reg.code == SC_GC_ACK && q_reg.flag);
  COV_LAST_ACK: cover property (q_reg.code == SC_TX_LAST && q_reg.flag);
  COV_STOP: cover property (q_reg.code == SC_STOP && q_reg.flag);

  initial begin
    if ($bits(twse_regs_type) < 1 || ADDR_W < 2) begin
      $error("twse_engine: register port too narrow");
    end
  end

endmodule : twse_engine

`default_nettype wire

// ===== tb/twse_bus_master.sv
// bus master model for the two-wire slave engine: start, stop and
// whole bytes, with 800 ns bit slots; lines are open drain.
// assumes the bench resolves scl_w/sda_w as wired-and with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module twse_bus_master (
  input  wire logic clk,
  input  wire logic scl_w,
  input  wire logic sda_w,
  output var  logic scl_m,
  output var  logic sda_m
);
  // ---------------------------------------------------------------
  // bit slot and framing
  // ---------------------------------------------------------------
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  // keep all link edges 7 ns off any system clock edge
  task automatic sync_off();
    @(negedge clk);
    #7;
  endtask : sync_off

  // data changes mid-low, sampled at the end of high
  task automatic bit_slot(input logic b, output logic r);
    int n;
    n = 0;
    #200 sda_m = b;
    #200 scl_m = 1'b1;
    // honour stretching, bounded so a stuck line cannot hang the run
    while (scl_w !== 1'b1 && n < 3000) begin
      #10 n++;
    end
    #400 r = sda_w;
    scl_m = 1'b0;
  endtask : bit_slot

  task automatic start_cond();
    sync_off();
    #200 sda_m = 1'b0;
    #200 scl_m = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    sync_off();
    #200 sda_m = 1'b0;
    #200 scl_m = 1'b1;
    #200 sda_m = 1'b1;
    #400;
  endtask : stop_cond

  // msb first, then the slave's answer bit (0 means acknowledged)
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    sync_off();
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, ack);
  endtask : send_byte

  task automatic recv_byte(input logic mnack, output logic [7:0] d);
    logic r;
    sync_off();
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(mnack, r);
  endtask : recv_byte
endmodule : twse_bus_master
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the two-wire slave engine with a bus master
// assumes the engine's register map and codes from twse_pkg
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import twse_pkg::*;
  // ---------------------------------------------------------------
  // signals and wiring
  // ---------------------------------------------------------------
  logic          ref_clk = 1'b0;
  logic          resetn, deep_sleep, arb_lost, go_seen;
  twse_bus_type  bus;
  logic [7:0]    rd_data, d;
  twse_pins_type pins;
  logic          scl_m, sda_m, start_go, wake_req;
  wire logic     scl_w, sda_w;
  logic [6:0]    me;
  int            n_mismatch, checks;

  // pull-ups: released lines read high
  assign scl_w = scl_m & ~pins.scl_oe;
  assign sda_w = sda_m & ~pins.sda_oe;

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (start_go === 1'b1) go_seen <= 1'b1;

  twse_engine twse_engine_i (.ref_clk(ref_clk), .resetn(resetn),
    .bus(bus), .rd_data(rd_data), .scl_in(scl_w), .sda_in(sda_w),
    .pins(pins), .scl_out(), .sda_out(), .deep_sleep(deep_sleep),
    .arb_lost(arb_lost), .wake_req(wake_req), .start_go(start_go));
  twse_bus_master twse_bus_master_i (.clk(ref_clk), .scl_w(scl_w),
    .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));

  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  function automatic logic [7:0] tx_code(logic last, logic mnack);
    return mnack ? SC_TX_NACK : (last ? SC_TX_LAST : SC_TX_ACK);
  endfunction : tx_code

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge ref_clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk(nm, e, rd_data);
  endtask : rd_chk

  task automatic xfer_w(input logic [7:0] v, input logic [7:0] e_ack,
                        input logic [7:0] e_code);
    logic a;
    twse_bus_master_i.send_byte(v, a);
    // the code lands three clocks after the ack-bit fall reaches the pin
    repeat (3) @(posedge ref_clk);
    chk("ack", e_ack, {7'h00, a});
    rd_chk(OFS_STATE_CODE, e_code, "code");
  endtask : xfer_w

  task automatic xfer_r(input logic mnack, input logic [7:0] e_d,
                        input logic [7:0] e_code);
    logic [7:0] g;
    twse_bus_master_i.recv_byte(mnack, g);
    repeat (3) @(posedge ref_clk);
    chk("tx byte", e_d, g);
    rd_chk(OFS_STATE_CODE, e_code, "code");
  endtask : xfer_r

  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the sequence needs well under half a millisecond
  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    bus = '0;
    resetn = 1'b0;
    deep_sleep = 1'b0;
    arb_lost = 1'b0;
    go_seen = 1'b0;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(8));
    me = 7'($urandom_range(127, 1));
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk(OFS_CONTROL, 8'h00, "control");
    rd_chk(OFS_STATE_CODE, SC_NONE, "code");
    rd_chk(3'h5, 8'h00, "unmapped");
    reg_wr(OFS_OWN_ADDR, {me, 1'b1});
    reg_wr(OFS_CONTROL, 8'h44);
    rd_chk(OFS_OWN_ADDR, {me, 1'b1}, "own addr");
    // own write address, then a byte refused with ack off
    twse_bus_master_i.start_cond();
    xfer_w({me, 1'b0}, 8'h00, SC_OWN_W);
    chk("scl hold", 8'h01, {7'h00, pins.scl_oe});
    d = 8'($urandom);
    reg_wr(OFS_CONTROL, 8'h84);
    xfer_w(d, 8'h01, SC_RX_NACK);
    rd_chk(OFS_BYTE_BUF, d, "rx byte");
    reg_wr(OFS_CONTROL, 8'hC4);
    twse_bus_master_i.stop_cond();
    // general call: ack, then nack, then clear with a start request
    twse_bus_master_i.start_cond();
    xfer_w(8'h00, 8'h00, SC_GC_W);
    reg_wr(OFS_CONTROL, 8'hC4);
    xfer_w(d, 8'h00, SC_GC_ACK);
    reg_wr(OFS_CONTROL, 8'h84);
    xfer_w(~d, 8'h01, SC_GC_NACK);
    go_seen = 1'b0;
    reg_wr(OFS_CONTROL, 8'hE4);
    twse_bus_master_i.stop_cond();
    // stop detect, busy drop and the pulse take a few clocks after sda
    repeat (3) @(posedge ref_clk);
    chk("start go", 8'h01, {7'h00, go_seen});
    reg_wr(OFS_CONTROL, 8'h44);
    // general call disabled, then ack enable off: no answer at all
    reg_wr(OFS_OWN_ADDR, {me, 1'b0});
    twse_bus_master_i.start_cond();
    xfer_w(8'h00, 8'h01, SC_NONE);
    twse_bus_master_i.stop_cond();
    reg_wr(OFS_CONTROL, 8'h04);
    twse_bus_master_i.start_cond();
    xfer_w({me, 1'b0}, 8'h01, SC_NONE);
    twse_bus_master_i.stop_cond();
    reg_wr(OFS_CONTROL, 8'h44);
    // transmit: last byte answered by ack (k=0) or nack (k=1)
    for (int k = 0; k < 2; k++) begin
      twse_bus_master_i.start_cond();
      xfer_w({me, 1'b1}, 8'h00, SC_OWN_R);
      d = 8'($urandom);
      reg_wr(OFS_BYTE_BUF, d);
      reg_wr(OFS_CONTROL, 8'hC4);
      xfer_r(1'b0, d, tx_code(1'b0, 1'b0));
      d = 8'($urandom);
      reg_wr(OFS_BYTE_BUF, d);
      reg_wr(OFS_CONTROL, 8'h84);
      xfer_r(k[0], d, tx_code(1'b1, k[0]));
      reg_wr(OFS_CONTROL, 8'hC4);
      xfer_r(1'b1, 8'hFF, SC_NONE);
      twse_bus_master_i.stop_cond();
    end
    // lost arbitration, then stop in mid data phase
    arb_lost <= 1'b1;
    twse_bus_master_i.start_cond();
    xfer_w({me, 1'b1}, 8'h00, SC_ARB_R);
    arb_lost <= 1'b0;
    reg_wr(OFS_BYTE_BUF, 8'hFF);
    reg_wr(OFS_CONTROL, 8'hC4);
    twse_bus_master_i.stop_cond();
    rd_chk(OFS_STATE_CODE, SC_STOP, "code");
    reg_wr(OFS_CONTROL, 8'hC4);
    // address match while in clock-stopped sleep
    deep_sleep <= 1'b1;
    twse_bus_master_i.start_cond();
    xfer_w({me, 1'b0}, 8'h00, SC_OWN_W);
    chk("wake", 8'h01, {7'h00, wake_req});
    chk("scl hold", 8'h01, {7'h00, pins.scl_oe});
    deep_sleep <= 1'b0;
    reg_wr(OFS_CONTROL, 8'hC4);
    twse_bus_master_i.stop_cond();
    rd_chk(OFS_STATE_CODE, SC_STOP, "code");
    reg_wr(OFS_CONTROL, 8'hC4);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
